// [verilog/cfg_bank_pkg.sv]
/*
  Package for the configuration word bank: register indices, masks,
  reset images, field positions, decode constants and carrier types.
  Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
*/
package cfg_bank_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [23:0] IDX_CFG1_LO = 24'h300000;
  localparam logic [23:0] IDX_CFG1_HI = 24'h300001;
  localparam logic [23:0] IDX_CFG2_LO = 24'h300002;
  localparam logic [23:0] IDX_CFG2_HI = 24'h300003;
  localparam logic [23:0] IDX_CFG3_LO = 24'h300004;
  localparam logic [23:0] IDX_CFG3_HI = 24'h300005;
  localparam logic [23:0] IDX_ID_LO = 24'h3FFFFE;
  localparam logic [23:0] IDX_ID_HI = 24'h3FFFFF;
  localparam logic [5:0] ADDR_TOP_ZERO = 6'h00;

  // internal register selectors (0..5 are the configuration bytes)
  localparam logic [2:0] SEL_LAST_CFG = 3'h5;
  localparam logic [2:0] SEL_ID_LO = 3'h6;
  localparam logic [2:0] SEL_ID_HI = 3'h7;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // implemented bits and power-on image, element 0 = lowest register
  localparam logic [5:0][7:0] IMPL_MASK = {8'h07, 8'hF8, 8'h0F, 8'hC7, 8'h04, 8'hE1};
  localparam logic [5:0][7:0] RESET_VAL = {8'h07, 8'hF8, 8'h0F, 8'hC7, 8'h04, 8'hC1};

  // program memory byte address of the stored configuration image
  localparam logic [20:0] CFG_IMAGE_BASE = 21'h1FFFF8;

  // field positions inside the configuration bytes
  localparam int BIT_DEBUG = 7;
  localparam int BIT_EXT_ISA = 6;
  localparam int BIT_STACK_RST = 5;
  localparam int BIT_WDOG_CFG = 0;
  localparam int BIT_CODE_PROT = 2;
  localparam int BIT_TWO_SPEED = 7;
  localparam int BIT_CLK_MON = 6;
  localparam int BIT_DEF_CLK = 2;
  localparam int BIT_BUS_WAIT = 7;
  localparam int BIT_BUS_WIDTH = 6;
  localparam int BIT_BUS_CFG = 4;
  localparam int BIT_ADDR_SHIFT = 3;
  localparam int BIT_LED = 2;
  localparam int BIT_ECAP_MUX = 1;
  localparam int BIT_CAP2_MUX = 0;

  // decode values
  localparam logic [1:0] OSC_CTRL_DEFAULT = 2'h0;
  localparam logic [1:0] BUS_CFG_OFF = 2'h3;
  localparam logic [1:0] BUS_CFG_ADDR12 = 2'h2;
  localparam logic [1:0] BUS_CFG_ADDR16 = 2'h1;
  localparam logic [4:0] ADDR_BITS_NONE = 5'h00;
  localparam logic [4:0] ADDR_BITS_12 = 5'h0C;
  localparam logic [4:0] ADDR_BITS_16 = 5'h10;
  localparam logic [4:0] ADDR_BITS_20 = 5'h14;
  localparam logic [15:0] RATIO_ONE = 16'h0001;

  typedef enum logic [1:0] {LD_ISSUE, LD_WAIT, LD_DONE} load_state_type;

  // decoded controls handed to the consuming logic
  typedef struct packed {
    logic configLoaded;
    logic debugPinsDedicated;
    logic extendedIsaEnable;
    logic stackFaultResetEnable;
    logic watchdogActive;
    logic codeProtected;
    logic twoSpeedStartupEnable;
    logic clockMonitorEnable;
    logic systemClockInternal;
    logic oscExternalClock;
    logic oscPllAllowed;
    logic oscClockOutEnable;
    logic [3:0] watchdogPostscaleSelect;
    logic [15:0] watchdogDivideRatio;
    logic busWaitStatesEnabled;
    logic busWidth16;
    logic externalBusEnabled;
    logic [4:0] externalAddrBits;
    logic addressShiftEnable;
    logic linkLedPinsActive;
    logic eccpOnPortE;
    logic capTwoOnPrimaryPin;
    logic capTwoOnBusPin;
  } cfg_ctrl_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [2:0] sel;
  } data_phase_type;

  typedef struct packed {
    load_state_type ldState;
    logic [2:0] ldIdx;
    logic memRdEn;
    logic [20:0] memAddr;
    logic [5:0][7:0] cfg;
    logic [5:0][7:0] lock;
    data_phase_type dph;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    cfg_ctrl_type ctrl;
  } bank_state_type;

endpackage : cfg_bank_pkg

// [verilog/cfg_word_bank.sv]
/*
  Configuration word bank: six write-once configuration bytes loaded
  from program memory at power-up, two read-only identity bytes, an
  AHB-Lite slave for software access and registered decoded controls.
  Assumes sys_rst is the power-on reset, warmRst any other reset, and
  a program memory read port that answers a request with memRdValid.
*/
// Our own choice: the AHB-Lite slave port.
// Overview of operation
// - implemented bits loaded as one take only first write; bits loaded as zero take none
// - unimplemented bits read zero, ignore writes
// - debug bit one frees pins, zero dedicates
// - extended isa bit one enables extension
// - stack fault reset bit resets to zero
// - watchdog config one forces watchdog on
// - code protect bit zero protects memory
// - two-speed start-up bit one enables it
// - clock monitor bit one enables monitor
// - default clock select when control is 00
// - oscillator select field decodes four modes
// - postscale ratio is two to field
// - bus wait bit one disables wait states
// - bus width bit: one 16-bit, zero 8-bit
// - bus config field selects addressing mode
// - address shift one offsets to zero
// - led enable routes link leds when active
// - enhanced capture mux picks port group
// - second capture mux picks output pin
// - identity bytes hold part and revision codes
// - identity bytes are read-only
// - power-on reset restores image; others keep
// - power-up loads image from program memory
`timescale 1ns/10ps
module cfg_word_bank #(
  parameter logic [10:0] PART_CODE = 11'h2A5, // arbitrary value
  parameter logic [4:0] REVISION_CODE = 5'h03 // arbitrary value
) (
  // clock, enable and resets
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic warmRst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // program memory read port for the power-up load
  output logic memRdEn,
  output logic [20:0] memAddr,
  input wire logic [7:0] memRdData,
  input wire logic memRdValid,
  // live inputs from the rest of the core
  input wire logic [1:0] oscillatorControl,
  input wire logic watchdogSoftwareEnable,
  input wire logic ethernetEnabled,
  // decoded configuration
  output cfg_bank_pkg::cfg_ctrl_type ctrl
);

  cfg_bank_pkg::bank_state_type st_ff;
  cfg_bank_pkg::bank_state_type nxt_st;

  logic accept;
  logic [23:0] addrIdx;
  logic addrMapped;
  logic [2:0] addrSel;
  logic writeDone;
  logic [2:0] rdSel;

  // read mux over the bank; identity bytes are constants
  function automatic logic [7:0] readReg(input logic [2:0] sel,
                                         input logic [5:0][7:0] cfg);
    logic [7:0] val;
    val = 8'h00;
    if (sel == cfg_bank_pkg::SEL_ID_LO) begin
      val = {PART_CODE[2:0], REVISION_CODE};
    end else if (sel == cfg_bank_pkg::SEL_ID_HI) begin
      val = PART_CODE[10:3];
    end else begin
      val = cfg[sel] & cfg_bank_pkg::IMPL_MASK[sel];
    end
    return val;
  endfunction : readReg

  // address decode; the upper six address bits must be zero
  always_comb begin
    addrIdx = haddr[25:2];
    addrMapped = 1'b1;
    addrSel = 3'h0;
    if (haddr[31:26] != cfg_bank_pkg::ADDR_TOP_ZERO) begin
      addrMapped = 1'b0;
    end else begin
      case (addrIdx)
        cfg_bank_pkg::IDX_CFG1_LO: addrSel = 3'h0;
        cfg_bank_pkg::IDX_CFG1_HI: addrSel = 3'h1;
        cfg_bank_pkg::IDX_CFG2_LO: addrSel = 3'h2;
        cfg_bank_pkg::IDX_CFG2_HI: addrSel = 3'h3;
        cfg_bank_pkg::IDX_CFG3_LO: addrSel = 3'h4;
        cfg_bank_pkg::IDX_CFG3_HI: addrSel = 3'h5;
        cfg_bank_pkg::IDX_ID_LO: addrSel = cfg_bank_pkg::SEL_ID_LO;
        cfg_bank_pkg::IDX_ID_HI: addrSel = cfg_bank_pkg::SEL_ID_HI;
        default: addrMapped = 1'b0;
      endcase
    end
  end

  assign accept = hsel && htrans[1] && hready && !warmRst;
  assign writeDone = st_ff.dph.valid && st_ff.dph.write && st_ff.dph.mapped &&
                     st_ff.hreadyout && !warmRst;
  assign rdSel = accept ? addrSel : st_ff.dph.sel;

  // whole next state: load sequencer, bus slave, bank and decode
  always_comb begin
    nxt_st = st_ff;
    nxt_st.memRdEn = 1'b0;

    // power-up load of the stored image, lowest byte first
    case (st_ff.ldState)
      cfg_bank_pkg::LD_ISSUE: begin
        nxt_st.memRdEn = 1'b1;
        nxt_st.memAddr = cfg_bank_pkg::CFG_IMAGE_BASE + {18'h00000, st_ff.ldIdx};
        nxt_st.ldState = cfg_bank_pkg::LD_WAIT;
      end
      cfg_bank_pkg::LD_WAIT: begin
        if (memRdValid) begin
          // a loaded zero counts as programmed and locks the bit
          nxt_st.cfg[st_ff.ldIdx] = memRdData & cfg_bank_pkg::IMPL_MASK[st_ff.ldIdx];
          nxt_st.lock[st_ff.ldIdx] = cfg_bank_pkg::IMPL_MASK[st_ff.ldIdx] & ~memRdData;
          if (st_ff.ldIdx == cfg_bank_pkg::SEL_LAST_CFG) begin
            nxt_st.ldState = cfg_bank_pkg::LD_DONE;
          end else begin
            nxt_st.ldIdx = st_ff.ldIdx + 3'h1;
            nxt_st.ldState = cfg_bank_pkg::LD_ISSUE;
          end
        end
      end
      cfg_bank_pkg::LD_DONE: begin
        nxt_st.ldState = cfg_bank_pkg::LD_DONE;
      end
      default: begin
        nxt_st.ldState = cfg_bank_pkg::LD_DONE;
      end
    endcase

    // write completes at the end of its data phase; identity ignored
    if (writeDone && st_ff.dph.sel <= cfg_bank_pkg::SEL_LAST_CFG) begin
      nxt_st.cfg[st_ff.dph.sel] =
        (st_ff.cfg[st_ff.dph.sel] & st_ff.lock[st_ff.dph.sel]) |
        (hwdata[7:0] & cfg_bank_pkg::IMPL_MASK[st_ff.dph.sel] &
         ~st_ff.lock[st_ff.dph.sel]);
      nxt_st.lock[st_ff.dph.sel] = cfg_bank_pkg::IMPL_MASK[st_ff.dph.sel];
    end

    // data phase bookkeeping; a stalled phase stays pending
    if (warmRst) begin
      nxt_st.dph = '0;
    end else if (accept) begin
      nxt_st.dph.valid = 1'b1;
      nxt_st.dph.write = hwrite;
      nxt_st.dph.mapped = addrMapped;
      nxt_st.dph.sel = addrSel;
    end else if (st_ff.hreadyout) begin
      nxt_st.dph.valid = 1'b0;
    end

    // read data follows the bank after this cycle's write and load
    if (accept ? !hwrite : (st_ff.dph.valid && !st_ff.dph.write && !st_ff.hreadyout)) begin
      if (accept ? addrMapped : st_ff.dph.mapped) begin
        nxt_st.hrdata = {24'h000000, readReg(rdSel, nxt_st.cfg)};
      end else begin
        nxt_st.hrdata = 32'h00000000;
      end
    end

    // bus stalls while the image loads, so no access sees a half bank;
    // a warm reset must not open the bus early either
    nxt_st.hreadyout = (nxt_st.ldState == cfg_bank_pkg::LD_DONE);
    nxt_st.hresp = cfg_bank_pkg::HRESP_OKAY;

    // decoded controls, registered so every output comes off a flop
    nxt_st.ctrl.configLoaded = (nxt_st.ldState == cfg_bank_pkg::LD_DONE);
    nxt_st.ctrl.debugPinsDedicated = !nxt_st.cfg[0][cfg_bank_pkg::BIT_DEBUG];
    nxt_st.ctrl.extendedIsaEnable = nxt_st.cfg[0][cfg_bank_pkg::BIT_EXT_ISA];
    nxt_st.ctrl.stackFaultResetEnable = nxt_st.cfg[0][cfg_bank_pkg::BIT_STACK_RST];
    // config bit forces the watchdog; software only matters when it is clear
    nxt_st.ctrl.watchdogActive = nxt_st.cfg[0][cfg_bank_pkg::BIT_WDOG_CFG] ||
                                 watchdogSoftwareEnable;
    nxt_st.ctrl.codeProtected = !nxt_st.cfg[1][cfg_bank_pkg::BIT_CODE_PROT];
    nxt_st.ctrl.twoSpeedStartupEnable = nxt_st.cfg[2][cfg_bank_pkg::BIT_TWO_SPEED];
    nxt_st.ctrl.clockMonitorEnable = nxt_st.cfg[2][cfg_bank_pkg::BIT_CLK_MON];
    nxt_st.ctrl.systemClockInternal = (oscillatorControl == cfg_bank_pkg::OSC_CTRL_DEFAULT) &&
                                      !nxt_st.cfg[2][cfg_bank_pkg::BIT_DEF_CLK];

    // oscillator mode decode
    case (nxt_st.cfg[2][1:0])
      2'h3: begin
        nxt_st.ctrl.oscExternalClock = 1'b1;
        nxt_st.ctrl.oscPllAllowed = 1'b1;
        nxt_st.ctrl.oscClockOutEnable = 1'b1;
      end
      2'h2: begin
        nxt_st.ctrl.oscExternalClock = 1'b1;
        nxt_st.ctrl.oscPllAllowed = 1'b0;
        nxt_st.ctrl.oscClockOutEnable = 1'b1;
      end
      2'h1: begin
        nxt_st.ctrl.oscExternalClock = 1'b0;
        nxt_st.ctrl.oscPllAllowed = 1'b1;
        nxt_st.ctrl.oscClockOutEnable = 1'b0;
      end
      default: begin
        nxt_st.ctrl.oscExternalClock = 1'b0;
        nxt_st.ctrl.oscPllAllowed = 1'b0;
        nxt_st.ctrl.oscClockOutEnable = 1'b0;
      end
    endcase

    // postscale: ratio is a one-hot power of two, 1:1 up to 1:32768
    nxt_st.ctrl.watchdogPostscaleSelect = nxt_st.cfg[3][3:0];
    nxt_st.ctrl.watchdogDivideRatio = cfg_bank_pkg::RATIO_ONE << nxt_st.cfg[3][3:0];

    // external memory bus
    nxt_st.ctrl.busWaitStatesEnabled = !nxt_st.cfg[4][cfg_bank_pkg::BIT_BUS_WAIT];
    nxt_st.ctrl.busWidth16 = nxt_st.cfg[4][cfg_bank_pkg::BIT_BUS_WIDTH];
    case (nxt_st.cfg[4][cfg_bank_pkg::BIT_BUS_CFG +: 2])
      cfg_bank_pkg::BUS_CFG_OFF: begin
        nxt_st.ctrl.externalBusEnabled = 1'b0;
        nxt_st.ctrl.externalAddrBits = cfg_bank_pkg::ADDR_BITS_NONE;
      end
      cfg_bank_pkg::BUS_CFG_ADDR12: begin
        nxt_st.ctrl.externalBusEnabled = 1'b1;
        nxt_st.ctrl.externalAddrBits = cfg_bank_pkg::ADDR_BITS_12;
      end
      cfg_bank_pkg::BUS_CFG_ADDR16: begin
        nxt_st.ctrl.externalBusEnabled = 1'b1;
        nxt_st.ctrl.externalAddrBits = cfg_bank_pkg::ADDR_BITS_16;
      end
      default: begin
        nxt_st.ctrl.externalBusEnabled = 1'b1;
        nxt_st.ctrl.externalAddrBits = cfg_bank_pkg::ADDR_BITS_20;
      end
    endcase
    nxt_st.ctrl.addressShiftEnable = nxt_st.cfg[4][cfg_bank_pkg::BIT_ADDR_SHIFT];

    // pin sharing; led pins follow the link module's enable live
    nxt_st.ctrl.linkLedPinsActive = nxt_st.cfg[5][cfg_bank_pkg::BIT_LED] &&
                                    ethernetEnabled;
    nxt_st.ctrl.eccpOnPortE = nxt_st.cfg[5][cfg_bank_pkg::BIT_ECAP_MUX];
    nxt_st.ctrl.capTwoOnPrimaryPin = nxt_st.cfg[5][cfg_bank_pkg::BIT_CAP2_MUX];
    // alternate pin depends on whether the external bus is in use
    nxt_st.ctrl.capTwoOnBusPin = !nxt_st.cfg[5][cfg_bank_pkg::BIT_CAP2_MUX] &&
                                 nxt_st.ctrl.externalBusEnabled;
  end

  // single state register; only power-on reset touches the bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.ldState <= cfg_bank_pkg::LD_ISSUE;
      st_ff.cfg <= cfg_bank_pkg::RESET_VAL;
      st_ff.hreadyout <= 1'b1;
      st_ff.ctrl.extendedIsaEnable <= 1'b1;
      st_ff.ctrl.watchdogActive <= 1'b1;
      st_ff.ctrl.twoSpeedStartupEnable <= 1'b1;
      st_ff.ctrl.clockMonitorEnable <= 1'b1;
      st_ff.ctrl.oscExternalClock <= 1'b1;
      st_ff.ctrl.oscPllAllowed <= 1'b1;
      st_ff.ctrl.oscClockOutEnable <= 1'b1;
      st_ff.ctrl.watchdogPostscaleSelect <= 4'hF;
      st_ff.ctrl.watchdogDivideRatio <= 16'h8000;
      st_ff.ctrl.busWidth16 <= 1'b1;
      st_ff.ctrl.externalAddrBits <= cfg_bank_pkg::ADDR_BITS_NONE;
      st_ff.ctrl.addressShiftEnable <= 1'b1;
      st_ff.ctrl.eccpOnPortE <= 1'b1;
      st_ff.ctrl.capTwoOnPrimaryPin <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign hreadyout = st_ff.hreadyout;
  assign hresp = st_ff.hresp;
  assign hrdata = st_ff.hrdata;
  assign memRdEn = st_ff.memRdEn;
  assign memAddr = st_ff.memAddr;
  assign ctrl = st_ff.ctrl;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [47:0] lockFlat;
  logic [47:0] cfgFlat;
  assign lockFlat = st_ff.lock;
  assign cfgFlat = st_ff.cfg;

  sequence idReadAccept;
    ce && accept && !hwrite && addrMapped && addrSel == cfg_bank_pkg::SEL_ID_LO;
  endsequence

  sequence loadByteTaken;
    ce && st_ff.ldState == cfg_bank_pkg::LD_WAIT && memRdValid;
  endsequence

  write_once_a: assert property (
    ce |=> ((cfgFlat & $past(lockFlat)) == ($past(cfgFlat) & $past(lockFlat))))
    else $error("locked configuration bit changed");

  unimpl_zero_a: assert property (
    (st_ff.cfg & ~cfg_bank_pkg::IMPL_MASK) == '0)
    else $error("unimplemented configuration bit is set");

  por_image_a: assert property (
    $past(sys_rst) |-> (st_ff.cfg == cfg_bank_pkg::RESET_VAL && st_ff.lock == '0))
    else $error("power-on image wrong");

  cfg1_decode_a: assert property (
    ctrl.debugPinsDedicated == !st_ff.cfg[0][7] && ctrl.extendedIsaEnable == st_ff.cfg[0][6] &&
    ctrl.stackFaultResetEnable == st_ff.cfg[0][5] && ctrl.codeProtected == !st_ff.cfg[1][2])
    else $error("debug, isa, stack or protect decode wrong");

  watchdog_on_a: assert property (
    ce |=> ctrl.watchdogActive == (st_ff.cfg[0][0] | $past(watchdogSoftwareEnable)))
    else $error("watchdog enable decode wrong");

  sys_clock_a: assert property (
    ce |=> ctrl.systemClockInternal == ($past(oscillatorControl) == 2'h0 && !st_ff.cfg[2][2]))
    else $error("default clock select wrong");

  postscale_a: assert property (
    $onehot(ctrl.watchdogDivideRatio) && ctrl.watchdogDivideRatio[st_ff.cfg[3][3:0]])
    else $error("postscale ratio wrong");

  ext_bus_a: assert property (
    ctrl.externalBusEnabled == (st_ff.cfg[4][5:4] != 2'h3) &&
    (st_ff.cfg[4][5:4] != 2'h2 || ctrl.externalAddrBits == 5'h0C))
    else $error("external bus decode wrong");

  led_pins_a: assert property (
    ce |=> ctrl.linkLedPinsActive == (st_ff.cfg[5][2] && $past(ethernetEnabled)))
    else $error("led pin routing wrong");

  id_read_a: assert property (
    idReadAccept |=> hrdata == {24'h000000, PART_CODE[2:0], REVISION_CODE})
    else $error("identity read data wrong");

  load_byte_a: assert property (
    loadByteTaken |=> st_ff.cfg[$past(st_ff.ldIdx)] ==
      ($past(memRdData) & cfg_bank_pkg::IMPL_MASK[$past(st_ff.ldIdx)]))
    else $error("loaded byte not stored");

  load_stall_a: assert property (
    st_ff.ldState != cfg_bank_pkg::LD_DONE && !$past(sys_rst) |-> !hreadyout)
    else $error("bus not stalled during load");

  osc_mode_a: assert property (
    ctrl.oscExternalClock == st_ff.cfg[2][1] && ctrl.oscPllAllowed == st_ff.cfg[2][0] &&
    ctrl.oscClockOutEnable == st_ff.cfg[2][1])
    else $error("oscillator mode decode wrong");

  bus_mode_a: assert property (
    ctrl.busWaitStatesEnabled == !st_ff.cfg[4][7] && ctrl.busWidth16 == st_ff.cfg[4][6] &&
    ctrl.addressShiftEnable == st_ff.cfg[4][3])
    else $error("bus wait, width or shift decode wrong");

  pin_mux_a: assert property (
    ctrl.eccpOnPortE == st_ff.cfg[5][1] && ctrl.capTwoOnPrimaryPin == st_ff.cfg[5][0] &&
    ctrl.capTwoOnBusPin == (!st_ff.cfg[5][0] && st_ff.cfg[4][5:4] != 2'h3))
    else $error("capture pin routing wrong");

endmodule : cfg_word_bank

// [verification/device_configuration_word_bank_tb_top.sv]
/*
  Self-checking bench for the configuration word bank: power-up load,
  write-once bytes, identity bytes, unmapped access, decode and resets.
  Assumes the design package and a single 25 MHz clock; the bench itself
  answers the program memory read port.
*/
`timescale 1ns/10ps
module device_configuration_word_bank_tb_top;
  localparam logic [10:0] PART_CODE = 11'h2A5; // arbitrary value
  localparam logic [4:0] REVISION_CODE = 5'h03; // arbitrary value
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic warmRst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout, hresp, memRdEn, memRdValid = 1'b0;
  logic [31:0] hrdata;
  logic [20:0] memAddr;
  logic [7:0] memRdData = 8'h00;
  logic [1:0] oscCtl = 2'h0;
  logic wdSw = 1'b0;
  logic ethOn = 1'b0;
  logic ce = 1'b1;
  cfg_bank_pkg::cfg_ctrl_type ctrl;
  logic [7:0] img [6];
  logic [7:0] cfgM [6];
  logic [7:0] lockM [6];
  int failCount = 0;
  int numChecks = 0;
  int ldCnt = 0;
  int lat = 0;
  logic pend = 1'b0;
  logic [31:0] rd;

  // 40 ns period
  always #20 clk = ~clk;

  cfg_word_bank #(.PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE)) cfg_word_bank_inst (
    .clk(clk), .ce(ce), .sys_rst(sysRst), .warmRst(warmRst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .memRdEn(memRdEn), .memAddr(memAddr), .memRdData(memRdData),
    .memRdValid(memRdValid), .oscillatorControl(oscCtl),
    .watchdogSoftwareEnable(wdSw), .ethernetEnabled(ethOn), .ctrl(ctrl)
  );

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task report_and_stop;
    if (failCount == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // program memory answers after a random 1..3 cycle latency; data line churns when idle
  always @(posedge clk) begin
    // one assignment per signal and edge
    if (pend && lat == 1 && !sysRst && memRdEn !== 1'b1) begin
      memRdValid <= 1'b1;
      memRdData <= img[ldCnt];
    end else begin
      memRdValid <= 1'b0;
      memRdData <= 8'($urandom);
    end
    if (sysRst) begin
      ldCnt <= 0;
      pend <= 1'b0;
    end else if (memRdEn === 1'b1) begin
      check(memAddr, cfg_bank_pkg::CFG_IMAGE_BASE + ldCnt);
      pend <= 1'b1;
      lat <= $urandom_range(1, 3);
    end else if (pend && lat == 1) begin
      pend <= 1'b0;
      ldCnt <= ldCnt + 1;
    end else if (pend) begin
      lat <= lat - 1;
    end
  end

  // one single AHB-Lite transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= cfg_bank_pkg::HTRANS_NONSEQ;
    haddr <= {6'h00, idx, 2'h0};
    hwrite <= wr;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 300);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 600);
    rd = hrdata;
    check(hresp, cfg_bank_pkg::HRESP_OKAY);
    if (n >= 300) failCount++;
  endtask : bus

  // expected decoded controls from the bench's own copy of the bank
  function automatic cfg_bank_pkg::cfg_ctrl_type exp_ctrl();
    cfg_bank_pkg::cfg_ctrl_type e;
    e.configLoaded = 1'b1;
    e.debugPinsDedicated = ~cfgM[0][7];
    e.extendedIsaEnable = cfgM[0][6];
    e.stackFaultResetEnable = cfgM[0][5];
    e.watchdogActive = cfgM[0][0] | wdSw;
    e.codeProtected = ~cfgM[1][2];
    e.twoSpeedStartupEnable = cfgM[2][7];
    e.clockMonitorEnable = cfgM[2][6];
    e.systemClockInternal = (oscCtl == 2'h0) & ~cfgM[2][2];
    e.oscExternalClock = cfgM[2][1];
    e.oscPllAllowed = cfgM[2][0];
    e.oscClockOutEnable = cfgM[2][1];
    e.watchdogPostscaleSelect = cfgM[3][3:0];
    e.watchdogDivideRatio = 16'h0001 << cfgM[3][3:0];
    e.busWaitStatesEnabled = ~cfgM[4][7];
    e.busWidth16 = cfgM[4][6];
    e.externalBusEnabled = cfgM[4][5:4] != 2'h3;
    e.externalAddrBits = (cfgM[4][5:4] == 2'h3) ? 5'h00 : (cfgM[4][5:4] == 2'h2) ? 5'h0C :
                         (cfgM[4][5:4] == 2'h1) ? 5'h10 : 5'h14;
    e.addressShiftEnable = cfgM[4][3];
    e.linkLedPinsActive = cfgM[5][2] & ethOn;
    e.eccpOnPortE = cfgM[5][1];
    e.capTwoOnPrimaryPin = cfgM[5][0];
    e.capTwoOnBusPin = ~cfgM[5][0] & (cfgM[4][5:4] != 2'h3);
    return e;
  endfunction : exp_ctrl

  // reserved bits as software must keep them: high nibbles of the high
  // bytes set, bit 3 of the second byte clear
  function automatic logic [7:0] keep_reserved(input int i, input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (i % 2 == 1) begin
      r[7:4] = 4'hF;
    end
    if (i == 1) begin
      r[3] = 1'b0;
    end
    return r;
  endfunction : keep_reserved

  // power cycle with a given image; bits loaded as zero count as programmed
  task automatic power_on(input logic [7:0] fill, input bit rnd);
    for (int i = 0; i < 6; i++) begin
      img[i] = keep_reserved(i, rnd ? 8'($urandom) : fill);
      cfgM[i] = img[i] & cfg_bank_pkg::IMPL_MASK[i];
      lockM[i] = ~cfgM[i] & cfg_bank_pkg::IMPL_MASK[i];
    end
    sysRst <= 1'b1;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
  endtask : power_on

  // fresh live levels under a frozen clock enable, then let the decode settle
  task automatic live_check();
    cfg_bank_pkg::cfg_ctrl_type e;
    e = exp_ctrl();
    ce <= 1'b0;
    oscCtl <= 2'($urandom);
    wdSw <= 1'($urandom);
    ethOn <= 1'($urandom);
    repeat (3) @(posedge clk);
    check(ctrl, e);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    e = exp_ctrl();
    check(ctrl[44:37], e[44:37]);
    check(ctrl[36:13], e[36:13]);
    check(ctrl[12:0], e[12:0]);
  endtask : live_check

  task automatic read_all();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, cfg_bank_pkg::IDX_CFG1_LO + 24'(i), 32'h00000000);
      check(rd, {24'h000000, cfgM[i]});
    end
    bus(1'b0, cfg_bank_pkg::IDX_ID_LO, 32'h00000000);
    check(rd, {24'h000000, PART_CODE[2:0], REVISION_CODE});
    bus(1'b0, cfg_bank_pkg::IDX_ID_HI, 32'h00000000);
    check(rd, {24'h000000, PART_CODE[10:3]});
  endtask : read_all

  task automatic run_pass(input int pass);
    logic [31:0] wd;
    read_all();
    live_check();
    // first write lands on free bits, the second must change nothing
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 6; i++) begin
        wd = (pass == 0 && r == 0) ? 32'hFFFFFF00 : $urandom;
        wd[7:0] = keep_reserved(i, wd[7:0]);
        bus(1'b1, cfg_bank_pkg::IDX_CFG1_LO + 24'(i), wd);
        cfgM[i] = (cfgM[i] & lockM[i]) | (wd[7:0] & cfg_bank_pkg::IMPL_MASK[i] & ~lockM[i]);
        lockM[i] = cfg_bank_pkg::IMPL_MASK[i];
        bus(1'b0, cfg_bank_pkg::IDX_CFG1_LO + 24'(i), 32'h00000000);
        check(rd, {24'h000000, cfgM[i]});
      end
      live_check();
    end
    // identity and unmapped places shrug off writes
    bus(1'b1, cfg_bank_pkg::IDX_ID_LO, $urandom);
    bus(1'b1, cfg_bank_pkg::IDX_ID_HI, $urandom);
    bus(1'b1, 24'h300006, $urandom);
    bus(1'b0, 24'h300006, 32'h00000000);
    check(rd, 32'h00000000);
    warmRst <= 1'b1;
    repeat (2) @(posedge clk);
    warmRst <= 1'b0;
    @(posedge clk);
    read_all(); // identity bytes unchanged after writes
    live_check();
  endtask : run_pass

  initial begin
    void'($urandom(32'hB7E0));
    power_on(8'hFF, 1'b0);
    run_pass(0);
    power_on(8'h00, 1'b1);
    run_pass(1);
    report_and_stop;
  end

  // hang guard, far beyond the few hundred cycles the passes need
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    report_and_stop;
  end
endmodule : device_configuration_word_bank_tb_top
